// ### rlq_consts.svh
// Constants of the read latency query table and its serial access port.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef RLQ_CONSTS_SVH
`define RLQ_CONSTS_SVH

// Serial access port
`define RLQ_CMD_QUERY   8'h5A
`define RLQ_BIT_LAST    3'h7
`define RLQ_OFF_FIRST   8'h00
`define RLQ_OFF_LAST    8'h57
`define RLQ_FILL        8'h00
`define RLQ_BYTE_RST    8'h00
`define RLQ_CNT_RST     3'h0

// Parameter header bytes
`define RLQ_PARAM_ID    8'h90
`define RLQ_PARAM_LEN   8'h56
`define RLQ_NUM_ROWS    8'h06
`define RLQ_ROW_LEN     8'h0E
`define RLQ_ASCII_F     8'h46
`define RLQ_ASCII_C     8'h43

// Read instruction codes, 3-byte then 4-byte address form
`define RLQ_RD_3B       8'h03
`define RLQ_RD_4B       8'h13
`define RLQ_FAST_3B     8'h0B
`define RLQ_FAST_4B     8'h0C
`define RLQ_DOUT_3B     8'h3B
`define RLQ_DOUT_4B     8'h3C
`define RLQ_QOUT_3B     8'h6B
`define RLQ_QOUT_4B     8'h6C
`define RLQ_DIO_3B      8'hBB
`define RLQ_DIO_4B      8'hBC
`define RLQ_QIO_3B      8'hEB
`define RLQ_QIO_4B      8'hEC

// Frequency limits and latency codes of the rows
`define RLQ_F50MHZ      8'h32
`define RLQ_F80MHZ      8'h50
`define RLQ_F90MHZ      8'h5A
`define RLQ_F104MHZ     8'h68
`define RLQ_F133MHZ     8'h85
`define RLQ_LC_11       8'h03
`define RLQ_LC_00       8'h00
`define RLQ_LC_01       8'h01
`define RLQ_LC_10       8'h02

// Mode and dummy cycle counts
`define RLQ_CYC0        8'h00
`define RLQ_CYC1        8'h01
`define RLQ_CYC2        8'h02
`define RLQ_CYC4        8'h04
`define RLQ_CYC5        8'h05
`define RLQ_CYC6        8'h06
`define RLQ_CYC8        8'h08
`define RLQ_NOSUP       8'hFF

`endif

// ### rlq_pkg.sv
// Types shared by the query table port and its table memory.
// Assumes nothing of its surroundings.
package rlq_pkg;

    typedef logic [7:0] rlq_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DATA,
        ST_IGNORE
    } rlq_state_t;

endpackage : rlq_pkg

// ### rlq_rom.sv
// Read-only table memory holding every byte of the latency query parameter.
// Assumes reads one cycle ahead of use; data come from a register.
`timescale 1ns/100ps
`include "rlq_consts.svh"

module rlq_rom
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              rd_en_i,
    input  wire rlq_pkg::rlq_byte_t rd_addr_i,
    output rlq_pkg::rlq_byte_t     rd_data_o
);
    import rlq_pkg::*;

    // Constant contents, one byte per relative offset
    function automatic rlq_byte_t rom_byte(input rlq_byte_t a);
        rlq_byte_t d;
        d = `RLQ_FILL;
        case (a)
            8'h00: d = `RLQ_PARAM_ID;  // [R1]
            8'h01: d = `RLQ_PARAM_LEN; // [R2]
            8'h02: d = `RLQ_NUM_ROWS;  // [R3]
            8'h03: d = `RLQ_ROW_LEN;   // [R3]
            8'h04: d = `RLQ_ASCII_F;   // [R3]
            8'h05: d = `RLQ_ASCII_C;   // [R3]
            8'h06: d = `RLQ_RD_3B;     // [R4]
            8'h07: d = `RLQ_RD_4B;     // [R4]
            8'h08: d = `RLQ_FAST_3B;   // [R5]
            8'h09: d = `RLQ_FAST_4B;   // [R5]
            8'h0A: d = `RLQ_DOUT_3B;   // [R6]
            8'h0B: d = `RLQ_DOUT_4B;   // [R6]
            8'h0C: d = `RLQ_QOUT_3B;   // [R7]
            8'h0D: d = `RLQ_QOUT_4B;   // [R7]
            8'h0E: d = `RLQ_DIO_3B;    // [R8]
            8'h0F: d = `RLQ_DIO_4B;    // [R8]
            8'h10: d = `RLQ_QIO_3B;    // [R9]
            8'h11: d = `RLQ_QIO_4B;    // [R9]
            8'h12: d = `RLQ_F50MHZ;    // [R10]
            8'h13: d = `RLQ_LC_11;     // [R10]
            8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
            8'h19, 8'h1A, 8'h1B: d = `RLQ_CYC0; // [R11]
            8'h1C: d = `RLQ_CYC0;      // [R12]
            8'h1D: d = `RLQ_CYC4;      // [R12]
            8'h1E: d = `RLQ_CYC2;      // [R13]
            8'h1F: d = `RLQ_CYC1;      // [R13]
            8'h20: d = `RLQ_F80MHZ;    // [R14]
            8'h21: d = `RLQ_LC_00;     // [R14]
            8'h22, 8'h23: d = `RLQ_NOSUP; // [R14]
            8'h24: d = `RLQ_CYC0;      // [R15]
            8'h25, 8'h27, 8'h29: d = `RLQ_CYC8; // [R16]
            8'h26, 8'h28, 8'h2A: d = `RLQ_CYC0;
            8'h2B: d = `RLQ_CYC4;
            8'h2C: d = `RLQ_CYC2;
            8'h2D: d = `RLQ_CYC4;
            8'h2E: d = `RLQ_F90MHZ;    // [R17]
            8'h2F: d = `RLQ_LC_01;     // [R17]
            8'h30, 8'h31: d = `RLQ_NOSUP; // [R17]
            8'h32, 8'h34, 8'h36, 8'h38: d = `RLQ_CYC0;
            8'h33, 8'h35, 8'h37: d = `RLQ_CYC8;
            8'h39: d = `RLQ_CYC5;
            8'h3A: d = `RLQ_CYC2;
            8'h3B: d = `RLQ_CYC4;
            8'h3C: d = `RLQ_F104MHZ;
            8'h3D: d = `RLQ_LC_10;
            8'h3E, 8'h3F: d = `RLQ_NOSUP;
            8'h40, 8'h42, 8'h44, 8'h46: d = `RLQ_CYC0;
            8'h41, 8'h43, 8'h45: d = `RLQ_CYC8;
            8'h47: d = `RLQ_CYC6;
            8'h48: d = `RLQ_CYC2;
            8'h49: d = `RLQ_CYC5;
            8'h4A: d = `RLQ_F133MHZ;
            8'h4B: d = `RLQ_LC_10;
            8'h4E: d = `RLQ_CYC0;
            8'h4F: d = `RLQ_CYC8;
            8'h4C, 8'h4D, 8'h50, 8'h51, 8'h52, 8'h53,
            8'h54, 8'h55, 8'h56, 8'h57: d = `RLQ_NOSUP;
            default: d = `RLQ_FILL;    // Past the last byte
        endcase
        return d;
    endfunction : rom_byte

    // Registered read port; there is no write port at all
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rd_data_o <= `RLQ_BYTE_RST;
        else if (rd_en_i)
            rd_data_o <= rom_byte(rd_addr_i); // [R18]
    end

    // Key bytes appear one cycle after their read
    a_id_byte: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1]
        rd_en_i && rd_addr_i == 8'h00 |=> rd_data_o == 8'h90)
        else $error("identifier byte wrong");
    a_len_byte: assert property (@(posedge mclk_i) disable iff (rst_i) // [R2]
        rd_en_i && rd_addr_i == 8'h01 |=> rd_data_o == 8'h56)
        else $error("length byte wrong");
    a_qio_mode: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        rd_en_i && rd_addr_i == 8'h1E |=> rd_data_o == 8'h02)
        else $error("quad io mode cycles wrong");
    a_row3_nosup: assert property (@(posedge mclk_i) disable iff (rst_i) // [R14]
        rd_en_i && rd_addr_i == 8'h22 |=> rd_data_o == 8'hFF)
        else $error("row 3 read not marked unsupported");
    a_fast_lat8: assert property (@(posedge mclk_i) disable iff (rst_i) // [R16]
        rd_en_i && rd_addr_i == 8'h25 |=> rd_data_o == 8'h08)
        else $error("row 3 fast latency wrong");

endmodule : rlq_rom

// ### rlq_query_port.sv
// What this block does
// R1 - Offset 00h reads identifier 90h
// R2 - Offset 01h reads length 56h
// R3 - Six rows of 0Eh bytes, F/C labels
// R4 - Header gives normal read codes 03h, 13h
// R5 - Header gives fast read codes 0Bh, 0Ch
// R6 - Header gives dual-out codes 3Bh, 3Ch
// R7 - Header gives quad-out codes 6Bh, 6Ch
// R8 - Header gives dual io codes BBh, BCh
// R9 - Header gives quad io codes EBh, ECh
// R10 - Row 2: 50 MHz, latency code 11b
// R11 - Code 11b: simple reads need no cycles
// R12 - Code 11b: dual io four dummy cycles
// R13 - Code 11b: quad io two mode, one dummy
// R14 - Row 3: 80 MHz, code 00b, no read
// R15 - Code 00b: fast read zero mode cycles
// R16 - Code 00b: eight dummy cycles for fast, dual-out, quad-out reads
// R17 - Row 4: 90 MHz, code 01b, no read
// R18 - Table is constant; host writes change nothing
//
// Serial port that serves the latency query table, one byte per offset.
// Assumes a host in clock mode 0 whose pins are foreign to mclk_i.
`timescale 1ns/100ps
`include "rlq_consts.svh"

module rlq_query_port
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic cs_n_i,
    input  wire logic sclk_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    output logic      miso_oe_n_o,
    output logic      busy_o
);
    import rlq_pkg::*;

    // Synchronisers and edge history
    logic       cs_n_m_ff;
    logic       cs_n_s_ff;
    logic       sclk_m_ff;
    logic       sclk_s_ff;
    logic       sclk_d_ff;
    logic       mosi_m_ff;
    logic       mosi_s_ff;

    // Transfer state
    rlq_state_t state_ff;
    rlq_state_t nxt_state;
    logic [2:0] cnt_ff;
    rlq_byte_t  rx_ff;
    rlq_byte_t  nxt_rx;
    rlq_byte_t  addr_ff;
    rlq_byte_t  tx_ff;
    logic       rd_en_ff;
    logic       rom_vld_ff;
    rlq_byte_t  rom_q;
    logic       miso_ff;
    logic       miso_oe_n_ff;
    logic       busy_ff;

    // Edge and byte events
    logic       sclk_rise;
    logic       sclk_fall;
    logic       byte_done;
    logic       sel;

    // Next offset, wrapping within the byte address space
    function automatic rlq_byte_t step_addr(input rlq_byte_t a);
        return rlq_byte_t'(a + 8'h01);
    endfunction : step_addr

    // Two flip-flops on every pin before any logic reads it
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cs_n_m_ff <= 1'b1;
            cs_n_s_ff <= 1'b1;
            sclk_m_ff <= 1'b0;
            sclk_s_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            mosi_m_ff <= 1'b0;
            mosi_s_ff <= 1'b0;
        end
        else
        begin
            cs_n_m_ff <= cs_n_i;
            cs_n_s_ff <= cs_n_m_ff;
            sclk_m_ff <= sclk_i;
            sclk_s_ff <= sclk_m_ff;
            sclk_d_ff <= sclk_s_ff;
            mosi_m_ff <= mosi_i;
            mosi_s_ff <= mosi_m_ff;
        end
    end

    // Serial clock edges seen only while selected
    assign sel       = ~cs_n_s_ff;
    assign sclk_rise = sel & sclk_s_ff & ~sclk_d_ff;
    assign sclk_fall = sel & ~sclk_s_ff & sclk_d_ff;
    assign byte_done = sclk_rise && (cnt_ff == `RLQ_BIT_LAST);
    assign nxt_rx    = {rx_ff[6:0], mosi_s_ff};

    // Bit counter, cleared whenever the host deselects
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !sel)
            cnt_ff <= `RLQ_CNT_RST;
        else if (sclk_rise)
            cnt_ff <= 3'(cnt_ff + 3'h1);
    end

    // Input shifter, most significant bit first
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rx_ff <= `RLQ_BYTE_RST;
        else if (sclk_rise)
            rx_ff <= nxt_rx;
    end

    // Transfer sequence: command, offset, then data bytes
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (sel)
                    nxt_state = ST_CMD;
            end
            ST_CMD:
            begin
                if (byte_done)
                    nxt_state = (nxt_rx == `RLQ_CMD_QUERY) ? ST_ADDR
                                                          : ST_IGNORE; // [R18]
            end
            ST_ADDR:
            begin
                if (byte_done)
                    nxt_state = ST_DATA;
            end
            ST_DATA:
            begin
                nxt_state = ST_DATA;
            end
            ST_IGNORE:
            begin
                nxt_state = ST_IGNORE; // [R18]
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (!sel)
            nxt_state = ST_IDLE;
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Offset capture and advance after each data byte
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            addr_ff <= `RLQ_OFF_FIRST;
        else if (state_ff == ST_ADDR && byte_done)
            addr_ff <= nxt_rx;
        else if (state_ff == ST_DATA && byte_done)
            addr_ff <= step_addr(addr_ff); // [R18]
    end

    // Table read request, one per offset or data byte boundary
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rd_en_ff <= 1'b0;
        else
            rd_en_ff <= byte_done &&
                        (state_ff == ST_ADDR || state_ff == ST_DATA);
    end

    // Read data valid one cycle after the request
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rom_vld_ff <= 1'b0;
        else
            rom_vld_ff <= rd_en_ff;
    end

    // Constant table; the port offers no way to write it
    rlq_rom u_rom
    (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .rd_en_i   (rd_en_ff),
        .rd_addr_i (addr_ff),
        .rd_data_o (rom_q)
    );

    // Output byte, loaded well before the next falling edge
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tx_ff <= `RLQ_BYTE_RST;
        else if (rom_vld_ff)
            tx_ff <= rom_q; // [R18]
    end

    // Data pin changes on the falling edge, bit 7 first
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            miso_ff <= 1'b0;
        else if (state_ff == ST_DATA && sclk_fall)
            miso_ff <= tx_ff[3'(`RLQ_BIT_LAST - cnt_ff)];
    end

    // Pin driven only while data bytes are being served
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            miso_oe_n_ff <= 1'b1;
        else
            miso_oe_n_ff <= ~(sel && state_ff == ST_DATA); // [R18]
    end

    // Selected indication
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            busy_ff <= 1'b0;
        else
            busy_ff <= sel;
    end

    assign miso_o      = miso_ff;
    assign miso_oe_n_o = miso_oe_n_ff;
    assign busy_o      = busy_ff;

    // Request followed by a loaded output byte
    sequence s_req;
        rd_en_ff;
    endsequence

    sequence s_loaded;
        ##2 (tx_ff == $past(rom_q));
    endsequence

    a_tx_load: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        s_req |-> s_loaded)
        else $error("output byte not loaded from table");

    a_ignore_quiet: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        state_ff == ST_IGNORE |=> miso_oe_n_ff)
        else $error("pin driven after a foreign command");

    a_oe_release: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        cs_n_s_ff |-> ##[1:2] miso_oe_n_ff)
        else $error("pin still driven after deselect");

    a_addr_step: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        state_ff == ST_DATA && byte_done
        |=> addr_ff == step_addr($past(addr_ff)))
        else $error("offset did not advance by one");

    a_query_enter: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        state_ff == ST_CMD && byte_done && nxt_rx == 8'h5A && sel
        |=> state_ff == ST_ADDR)
        else $error("query command not accepted");

    a_read_spacing: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        rd_en_ff |=> !rd_en_ff [*3])
        else $error("table read requests too close");

    // Top bit of each byte leaves on the first fall of that byte
    sequence s_first_fall;
        state_ff == ST_DATA && sclk_fall && cnt_ff == `RLQ_CNT_RST;
    endsequence

    a_msb_first: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        s_first_fall |=> miso_ff == $past(tx_ff[7]))
        else $error("data byte not sent top bit first");

    a_oe_in_data: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        state_ff == ST_DATA && sel |=> !miso_oe_n_ff)
        else $error("pin not driven during data bytes");

    a_ignore_noread: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        state_ff == ST_IGNORE |=> !rd_en_ff)
        else $error("table read after a foreign command");

    a_deselect_idle: assert property (@(posedge mclk_i) disable iff (rst_i) // [R18]
        !sel |=> state_ff == ST_IDLE && cnt_ff == `RLQ_CNT_RST)
        else $error("deselect did not end the transfer");

endmodule : rlq_query_port

// ### rlq_host_model.sv
// SPI host model that reads the latency query table in clock mode 0.
// Assumes the port under test samples these pins with its own faster clock.
`timescale 1ns/100ps

module rlq_host_model
(
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    import rlq_pkg::*;

    rlq_byte_t rx [0:127];
    logic      oe_seen;

    // Idle pins: deselected, serial clock parked low
    initial
    begin
        cs_n_o  = 1'b1;
        sclk_o  = 1'b0;
        mosi_o  = 1'b0;
        oe_seen = 1'b0;
    end

    // Notes whether the device drove miso during the current frame
    always @(miso_oe_n_i)
    begin
        if (miso_oe_n_i === 1'b0)
        begin
            oe_seen = 1'b1;
        end
    end

    // One serial clock: data set while low, miso taken on the rise
    task automatic bit_io(input logic b, output logic r);
        mosi_o = b;
        #62.5 sclk_o = 1'b1;
        r = (miso_oe_n_i === 1'b0) ? miso_i : ~miso_i;  // Undriven line shows no stale level
        #62.5 sclk_o = 1'b0;
    endtask : bit_io

    // Command, offset, then n whole data bytes; clock stands still between frames
    task automatic xfer(input rlq_byte_t cmd, input rlq_byte_t off, input int n);
        logic      r;
        rlq_byte_t sh;
        sh      = 8'h00;
        oe_seen = 1'b0;
        cs_n_o  = 1'b0;
        #62.5;
        for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
        for (int i = 7; i >= 0; i--) bit_io(off[i], r);
        for (int k = 0; k < n; k++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                bit_io(~mosi_o, r);  // Data phase: mosi is don't-care, keep it moving
                sh = {sh[6:0], r};
            end
            rx[k] = sh;
        end
        #62.5 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;  // Released line shows no stale level
        #100;
    endtask : xfer
endmodule : rlq_host_model

// ### read_latency_query_table_tb_top.sv
// Self-checking bench: host model reads the query table, a queue model predicts it.
// Assumes rlq_pkg, rlq_rom and rlq_query_port are compiled first.
`timescale 1ns/100ps

module read_latency_query_table_tb_top;
    import rlq_pkg::*;

    logic        mclk_i;
    logic        rst_i;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        miso_oe_n;
    logic        busy;
    logic [31:0] seed;
    int          n_mismatch;
    int          comparisons;
    rlq_byte_t   tab [$];
    rlq_byte_t   cmd;
    rlq_byte_t   nxt;

    // System clock, 100 MHz
    always #5 mclk_i = ~mclk_i;

    rlq_query_port dut
    (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .cs_n_i      (cs_n),
        .sclk_i      (sclk),
        .mosi_i      (mosi),
        .miso_o      (miso),
        .miso_oe_n_o (miso_oe_n),
        .busy_o      (busy)
    );

    rlq_host_model host
    (
        .miso_i      (miso),
        .miso_oe_n_i (miso_oe_n),
        .cs_n_o      (cs_n),
        .sclk_o      (sclk),
        .mosi_o      (mosi)
    );

    // Xorshift source for offsets and refused commands
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Predicted byte at an offset; beyond the table reads fill
    function automatic rlq_byte_t exp_at(input rlq_byte_t a);
        return (a < 8'h58) ? tab[a] : 8'h00;
    endfunction : exp_at

    task automatic chk(input string what, input rlq_byte_t exp, input rlq_byte_t got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // Read n bytes from offset a and compare each, offset wrapping at 8 bits
    task automatic read_chk(input rlq_byte_t a, input int n);
        host.xfer(8'h5A, a, n);
        for (int k = 0; k < n; k++)
            chk("table byte", exp_at(rlq_byte_t'(a + k)), host.rx[k]);
        chk("oe_n seen", 8'h01, {7'h00, host.oe_seen});
        chk("oe_n released", 8'h01, {7'h00, miso_oe_n});
        chk("busy after", 8'h00, {7'h00, busy});
    endtask : read_chk

    // Hang guard
    initial
    begin
        #900_000;
        n_mismatch++;
        $display("[ERR] run time expected done seen hang");
        end_of_test();
    end

    // Main sequence
    initial
    begin
        mclk_i      = 1'b0;
        rst_i       = 1'b1;
        seed        = 32'h0000_286E;
        n_mismatch  = 0;
        comparisons = 0;
        tab = {8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43};
        tab = {tab, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C};
        tab = {tab, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};
        tab = {tab, 8'h32, 8'h03};
        repeat (9) tab.push_back(8'h00);
        tab = {tab, 8'h04, 8'h02, 8'h01};
        tab = {tab, 8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00};
        tab = {tab, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};
        tab = {tab, 8'h00, 8'h04, 8'h02, 8'h04};
        tab = {tab, 8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08};
        tab = {tab, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h05, 8'h02, 8'h04};
        tab = {tab, 8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08};
        tab = {tab, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h06, 8'h02, 8'h05};
        tab = {tab, 8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08};
        repeat (8) tab.push_back(8'hFF);
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("idle oe_n", 8'h01, {7'h00, miso_oe_n});
        chk("idle busy", 8'h00, {7'h00, busy});
        // Whole table streamed, running past its end into fill
        read_chk(8'h00, 90);
        // Host locates the next parameter from the length byte
        nxt = 8'h01 + host.rx[1] + 8'h01;
        chk("next parameter", 8'h58, nxt);
        read_chk(nxt, 1);
        // Offset wrap from the top of the space back to the identifier
        read_chk(8'hFE, 3);
        // Selected while a transfer runs
        fork
            read_chk(8'h10, 2);
            begin
                #300;
                chk("busy", 8'h01, {7'h00, busy});
            end
        join
        // Foreign command is ignored and cannot alter the table
        cmd = rlq_byte_t'(rnd());
        if (cmd == 8'h5A)
            cmd = 8'h5B;
        host.xfer(cmd, 8'h00, 2);
        chk("oe_n on refused", 8'h00, {7'h00, host.oe_seen});
        read_chk(8'h00, 4);
        // Random starting offsets, two bytes each
        repeat (6) read_chk(rlq_byte_t'(rnd()), 2);
        end_of_test();
    end
endmodule : read_latency_query_table_tb_top
